/* rtl/acf_pkg.sv */
// constants and carrier types of the angular capture/compare event flag block
// assumes one clock domain and an 8-bit register port with read data one cycle later
package acf_pkg;

  // widths
  localparam int ACF_ADDR_W  = 4;
  localparam int ACF_DATA_W  = 8;
  localparam int ACF_PHASE_W = 16;
  localparam int ACF_NCH     = 3;

  // register offsets on the register port
  localparam logic [3:0] ACF_OFS_FLAGS   = 4'h0;
  localparam logic [3:0] ACF_OFS_SELECT  = 4'h1;
  localparam logic [3:0] ACF_OFS_CAP1_LO = 4'h2;
  localparam logic [3:0] ACF_OFS_CAP1_HI = 4'h3;
  localparam logic [3:0] ACF_OFS_CAP2_LO = 4'h4;
  localparam logic [3:0] ACF_OFS_CAP2_HI = 4'h5;
  localparam logic [3:0] ACF_OFS_CAP3_LO = 4'h6;
  localparam logic [3:0] ACF_OFS_CAP3_HI = 4'h7;

  // field positions in the flag and select registers
  localparam int ACF_BIT_CHAN1 = 0;
  localparam int ACF_BIT_CHAN2 = 1;
  localparam int ACF_BIT_CHAN3 = 2;

  // values after reset
  localparam logic [2:0]  ACF_FLAGS_RST  = 3'h0;
  localparam logic [2:0]  ACF_SELECT_RST = 3'h0;
  localparam logic [15:0] ACF_CAP_RST    = 16'h0000;
  localparam logic [7:0]  ACF_RDATA_RST  = 8'h00;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acf_req_t;

  // per-channel events from the timer datapath, bit 0 is channel one
  typedef struct packed {
    logic [2:0] cap;
    logic [2:0] cmp;
  } acf_evt_t;

endpackage : acf_pkg

/* rtl/acf_flag_cell.sv */
// one sticky event flag of a capture/compare channel
// assumes events and register writes come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module acf_flag_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // channel mode and events
  input  wire logic capture_sel,
  input  wire logic cap_evt,
  input  wire logic cmp_evt,
  // software write of this bit
  input  wire logic wr_en,
  input  wire logic wr_bit,
  // flag state
  output logic      flag,
  output logic      set_evt
);

  logic flag_q;

  // the event that counts depends on the channel's mode
  assign set_evt = capture_sel ? cap_evt : cmp_evt;

  // sticky flag, a hardware set beats a same-cycle software write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_q <= acf_pkg::ACF_FLAGS_RST[0];
    else if (set_evt)
      flag_q <= 1'h1;
    else if (wr_en)
      flag_q <= wr_bit;
  end

  // the flag register drives the port
  assign flag = flag_q;

endmodule : acf_flag_cell

`default_nettype wire

/* rtl/acf_event_flags.sv */
// event flag register of the three angular timer capture/compare channels
// assumes events and phase come from timer logic on SYS_CLK; software uses the register port
// Notes on behaviour
// - flag register bits 7 to 3 always read as zero
// - channel three in capture mode: capture sets bit 2, phase is stored
// - channel three in compare mode: compare event sets bit 2
// - zero flag means no event since clear; writing zero clears until next event
// - channel two in capture mode: capture sets bit 1, phase is stored
// - channel two in compare mode: compare event sets bit 1
// - channel one sets bit 0 on capture or compare by mode, capture stores phase
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module acf_event_flags (
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              ARST_N,
  // register port
  input  wire acf_pkg::acf_req_t REG_REQ,
  output logic [7:0]             REG_RDATA,
  // timer datapath
  input  wire acf_pkg::acf_evt_t EVT,
  input  wire logic [15:0]       PHASE,
  // state shown to the surrounding timer
  output logic [2:0]             FLAGS,
  output logic [2:0]             CAPTURE_SELECT
);

  logic [2:0]  flags;
  logic [2:0]  set_evt;
  logic [2:0]  sel_q;
  logic [15:0] cap_q [3];
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        wr_flags;
  logic        wr_select;

  // index of the channel addressed by a capture value offset
  function automatic logic [1:0] cap_chan(input logic [3:0] addr);
    logic [3:0] rel;
    rel = addr - acf_pkg::ACF_OFS_CAP1_LO;
    return rel[2:1];
  endfunction : cap_chan

  // true when an offset falls on one of the capture value bytes
  function automatic logic is_cap(input logic [3:0] addr);
    return (addr >= acf_pkg::ACF_OFS_CAP1_LO) && (addr <= acf_pkg::ACF_OFS_CAP3_HI);
  endfunction : is_cap

  // write decode
  assign wr_flags  = REG_REQ.wr && (REG_REQ.addr == acf_pkg::ACF_OFS_FLAGS);
  assign wr_select = REG_REQ.wr && (REG_REQ.addr == acf_pkg::ACF_OFS_SELECT);

  // channel mode selects, 1 = capture, 0 = compare
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      sel_q <= acf_pkg::ACF_SELECT_RST;
    else if (wr_select)
      sel_q <= REG_REQ.wdata[2:0];
  end

  // one sticky flag per channel
  genvar g;
  generate
    for (g = 0; g < acf_pkg::ACF_NCH; g++)
    begin : g_flag
      acf_flag_cell u_acf_flag_cell (
        .clk         (SYS_CLK),
        .arst_n      (ARST_N),
        .capture_sel (sel_q[g]),
        .cap_evt     (EVT.cap[g]),
        .cmp_evt     (EVT.cmp[g]),
        .wr_en       (wr_flags),
        .wr_bit      (REG_REQ.wdata[g]),
        .flag        (flags[g]),
        .set_evt     (set_evt[g])
      );
    end
  endgenerate

  // capture registers hold the phase at a capture event in capture mode
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cap_q[0] <= acf_pkg::ACF_CAP_RST;
      cap_q[1] <= acf_pkg::ACF_CAP_RST;
      cap_q[2] <= acf_pkg::ACF_CAP_RST;
    end
    else
    begin
      for (int i = 0; i < acf_pkg::ACF_NCH; i++)
      begin
        if (sel_q[i] && EVT.cap[i])
          cap_q[i] <= PHASE;
      end
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (REG_REQ.rd)
    begin
      if (REG_REQ.addr == acf_pkg::ACF_OFS_FLAGS)
        rdata_d = {5'h00, flags};
      else if (REG_REQ.addr == acf_pkg::ACF_OFS_SELECT)
        rdata_d = {5'h00, sel_q};
      else if (is_cap(REG_REQ.addr))
        rdata_d = REG_REQ.addr[0] ? cap_q[cap_chan(REG_REQ.addr)][15:8]
                                  : cap_q[cap_chan(REG_REQ.addr)][7:0];
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_q <= acf_pkg::ACF_RDATA_RST;
    else
      rdata_q <= rdata_d;
  end

  // outputs
  assign REG_RDATA      = rdata_q;
  assign FLAGS          = flags;
  assign CAPTURE_SELECT = sel_q;

  // checks on the behaviour above

  property p_upper_zero;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_REQ.rd && REG_REQ.addr == acf_pkg::ACF_OFS_FLAGS)
      |=> (REG_RDATA[7:3] == 5'h00) && (REG_RDATA[2:0] == $past(flags));
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("flag register upper bits or flags read wrong");

  property p_ch3_capture;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (sel_q[2] && EVT.cap[2]) |=> flags[2] && (cap_q[2] == $past(PHASE));
  endproperty
  a_ch3_capture: assert property (p_ch3_capture)
    else $error("channel three capture did not set flag or store phase");

  property p_ch3_compare;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!sel_q[2] && EVT.cmp[2]) |=> flags[2] && $stable(cap_q[2]);
  endproperty
  a_ch3_compare: assert property (p_ch3_compare)
    else $error("channel three compare did not set flag");

  property p_clear_holds;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (wr_flags && !REG_REQ.wdata[0] && !set_evt[0]) ##1 (!set_evt[0] && !wr_flags)
      |-> !flags[0] ##1 !flags[0];
  endproperty
  a_clear_holds: assert property (p_clear_holds)
    else $error("cleared flag did not stay zero without event");

  property p_ch2_capture;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (sel_q[1] && EVT.cap[1]) |=> flags[1] && (cap_q[1] == $past(PHASE));
  endproperty
  a_ch2_capture: assert property (p_ch2_capture)
    else $error("channel two capture did not set flag or store phase");

  property p_ch2_compare;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!sel_q[1] && EVT.cmp[1] && !EVT.cap[1]) |=> flags[1];
  endproperty
  a_ch2_compare: assert property (p_ch2_compare)
    else $error("channel two compare did not set flag");

  property p_ch1_event;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    ((sel_q[0] ? EVT.cap[0] : EVT.cmp[0])) |=> flags[0] && (cap_q[0] == ($past(sel_q[0]) ? $past(PHASE) : $past(cap_q[0])));
  endproperty
  a_ch1_event: assert property (p_ch1_event)
    else $error("channel one event handled wrong");

  property p_wrong_mode_ignored;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!flags[1] && !wr_flags && !(sel_q[1] ? EVT.cap[1] : EVT.cmp[1])) |=> !flags[1];
  endproperty
  a_wrong_mode_ignored: assert property (p_wrong_mode_ignored)
    else $error("flag set without a matching event");

  property p_set_wins;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (wr_flags && (REG_REQ.wdata[2:0] == 3'h0) && (set_evt != 3'h0)) |=> ((flags & $past(set_evt)) == $past(set_evt));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("software clear beat a hardware set");

  property p_reset_zero;
    @(posedge SYS_CLK)
    $rose(ARST_N) |-> (flags == acf_pkg::ACF_FLAGS_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("flags not zero after reset");

  property p_cap_stable;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !(sel_q[2] && EVT.cap[2]) |=> $stable(cap_q[2]);
  endproperty
  a_cap_stable: assert property (p_cap_stable)
    else $error("channel three capture value changed without capture");

  property p_ch2_cap_stable;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !(sel_q[1] && EVT.cap[1])
      |=> $stable(cap_q[1]);
  endproperty
  a_ch2_cap_stable: assert property (p_ch2_cap_stable)
    else $error("channel two capture value changed without capture");

  property p_ch1_cap_stable;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !(sel_q[0] && EVT.cap[0])
      |=> $stable(cap_q[0]);
  endproperty
  a_ch1_cap_stable: assert property (p_ch1_cap_stable)
    else $error("channel one capture value changed without capture");

  property p_ch3_wrong_mode_ignored;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!flags[2] && !wr_flags && !(sel_q[2] ? EVT.cap[2] : EVT.cmp[2]))
      |=> !flags[2];
  endproperty
  a_ch3_wrong_mode_ignored: assert property (p_ch3_wrong_mode_ignored)
    else $error("channel three flag set without a matching event");

  property p_ch1_wrong_mode_ignored;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!flags[0] && !wr_flags && !(sel_q[0] ? EVT.cap[0] : EVT.cmp[0]))
      |=> !flags[0];
  endproperty
  a_ch1_wrong_mode_ignored: assert property (p_ch1_wrong_mode_ignored)
    else $error("channel one flag set without a matching event");

  property p_write_takes;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    wr_flags
      |=> ((flags & ~$past(set_evt)) == ($past(REG_REQ.wdata[2:0]) & ~$past(set_evt)));
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("flag write without event did not take effect");

  property p_flags_hold;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (!wr_flags && ((EVT.cap & sel_q) == 3'h0) && ((EVT.cmp & ~sel_q) == 3'h0))
      |=> $stable(flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed without event or write");

  property p_select_write;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    wr_select
      |=> (sel_q == $past(REG_REQ.wdata[2:0]));
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("mode select write did not take effect");

  property p_select_hold;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !wr_select
      |=> $stable(sel_q);
  endproperty
  a_select_hold: assert property (p_select_hold)
    else $error("mode select changed without a write");

  property p_rdata_idle;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    !REG_REQ.rd
      |=> (REG_RDATA == acf_pkg::ACF_RDATA_RST);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero after a cycle without read");

  property p_unmapped_zero;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_REQ.rd && (REG_REQ.addr > acf_pkg::ACF_OFS_CAP3_HI))
      |=> (REG_RDATA == acf_pkg::ACF_RDATA_RST);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped offset read not zero");

  property p_ch3_cap_read;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_REQ.rd && (REG_REQ.addr == acf_pkg::ACF_OFS_CAP3_LO))
      |=> (REG_RDATA == $past(cap_q[2][7:0]));
  endproperty
  a_ch3_cap_read: assert property (p_ch3_cap_read)
    else $error("channel three capture low byte read wrong");

  property p_ch2_cap_read;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_REQ.rd && (REG_REQ.addr == acf_pkg::ACF_OFS_CAP2_HI))
      |=> (REG_RDATA == $past(cap_q[1][15:8]));
  endproperty
  a_ch2_cap_read: assert property (p_ch2_cap_read)
    else $error("channel two capture high byte read wrong");

  property p_ch1_cap_read;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (REG_REQ.rd && (REG_REQ.addr == acf_pkg::ACF_OFS_CAP1_LO))
      |=> (REG_RDATA == $past(cap_q[0][7:0]));
  endproperty
  a_ch1_cap_read: assert property (p_ch1_cap_read)
    else $error("channel one capture low byte read wrong");

endmodule : acf_event_flags

`default_nettype wire

/* dv/acf_event_flags_tb.sv */
// self-checking bench for the angular capture/compare event flag block
// assumes read data one cycle after a read strobe and flags one cycle after an event
`timescale 1ns/1ps
`default_nettype none

module acf_event_flags_tb;
  logic              sys_clk;
  logic              arst_n;
  acf_pkg::acf_req_t req;
  acf_pkg::acf_evt_t evt;
  logic [15:0]       phase;
  logic [7:0]        reg_rdata;
  logic [2:0]        flags;
  logic [2:0]        capture_select;
  int                errors;
  int                checks;
  logic [3:0]        lo_ofs;
  logic [15:0]       phs;

  acf_event_flags u_acf_event_flags (
    .SYS_CLK        (sys_clk),
    .ARST_N         (arst_n),
    .REG_REQ        (req),
    .REG_RDATA      (reg_rdata),
    .EVT            (evt),
    .PHASE          (phase),
    .FLAGS          (flags),
    .CAPTURE_SELECT (capture_select)
  );

  // clock at 250 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // compares a seen value with the expected one
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // one-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge sys_clk);
    req.wr    <= 1'b0;
    #1;
  endtask : reg_wr

  // one-cycle register read, data compared in the following cycle
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge sys_clk);
    req.rd   <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : reg_rd

  // one-cycle event pulse with a phase value beside it
  task automatic pulse(input logic [2:0] cap, input logic [2:0] cmp, input logic [15:0] ph);
    @(posedge sys_clk);
    evt.cap <= cap;
    evt.cmp <= cmp;
    phase   <= ph;
    @(posedge sys_clk);
    evt   <= '0;
    phase <= ~ph;
    #1;
  endtask : pulse

  // cuts a hang short
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    req    = '0;
    evt    = '0;
    phase  = 16'h0000;
    errors = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    // reset values of all offsets, one unmapped
    for (int a = 0; a < 9; a++)
      reg_rd(4'(a), 8'h00);
    chk(16'(flags), 16'h0000);
    // compare mode: capture ignored, compare sets the channel bit, zero write clears
    for (int i = 0; i < 3; i++)
    begin
      lo_ofs = acf_pkg::ACF_OFS_CAP1_LO + 4'(2 * i);
      pulse(3'(1 << i), 3'h0, 16'hBEEF);
      chk(16'(flags), 16'h0000);
      reg_rd(lo_ofs, 8'h00);
      pulse(3'h0, 3'(1 << i), 16'h0000);
      chk(16'(flags), 16'(1 << i));
      reg_rd(acf_pkg::ACF_OFS_FLAGS, 8'(1 << i));
      reg_wr(acf_pkg::ACF_OFS_FLAGS, 8'h00);
      chk(16'(flags), 16'h0000);
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'(flags), 16'h0000);
    end
    // capture mode: compare ignored, capture sets the bit and stores the phase
    reg_wr(acf_pkg::ACF_OFS_SELECT, 8'h07);
    chk(16'(capture_select), 16'h0007);
    reg_rd(acf_pkg::ACF_OFS_SELECT, 8'h07);
    for (int i = 0; i < 3; i++)
    begin
      lo_ofs = acf_pkg::ACF_OFS_CAP1_LO + 4'(2 * i);
      phs    = 16'hA50F + 16'(i) * 16'h1111;
      pulse(3'h0, 3'(1 << i), 16'h0000);
      chk(16'(flags), 16'h0000);
      pulse(3'(1 << i), 3'h0, phs);
      chk(16'(flags), 16'(1 << i));
      reg_rd(lo_ofs, phs[7:0]);
      reg_rd(lo_ofs + 4'h1, phs[15:8]);
      reg_wr(lo_ofs, 8'h55);
      reg_rd(lo_ofs, phs[7:0]);
      reg_wr(acf_pkg::ACF_OFS_FLAGS, 8'h00);
    end
    // upper bits of the flag register stay zero
    reg_wr(acf_pkg::ACF_OFS_FLAGS, 8'hFF);
    reg_rd(acf_pkg::ACF_OFS_FLAGS, 8'h07);
    reg_wr(acf_pkg::ACF_OFS_FLAGS, 8'h00);
    // capture on channel two in the same cycle as a clearing write
    @(posedge sys_clk);
    req.addr  <= acf_pkg::ACF_OFS_FLAGS;
    req.wdata <= 8'h00;
    req.wr    <= 1'b1;
    evt.cap   <= 3'h2;
    phase     <= 16'h0F0F;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    evt    <= '0;
    #1;
    chk(16'(flags), 16'h0002);
    // reset in mid-run clears flags, mode and stored phase
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1;
    chk(16'(flags), 16'h0000);
    chk(16'(capture_select), 16'h0000);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    reg_rd(acf_pkg::ACF_OFS_CAP2_LO, 8'h00);
    reg_rd(acf_pkg::ACF_OFS_SELECT, 8'h00);
    stop_test();
  end
endmodule : acf_event_flags_tb

`default_nettype wire
